// file: rtl/spnvm_ctrl.v
// Purpose: self-program access controller for on-chip nonvolatile storage
// Assumes: core issues register accesses on a plain port, one per clock
// Notes:   storage arrays sit outside; this block sequences and holds registers
// Notes on behaviour
// - write starts only after 55h then AAh on unlock port, then trigger set.
// - trigger bit cannot be set while arm bit is clear.
// - hardware never clears the arm bit.
// - clearing arm during a running write does not stop it.
// - data write end clears trigger and sets completion flag.
// - program read uses the second following cycle, that instruction discarded.
// - program read result lands in data low and high next cycle.
// - data registers keep a read result until new read or write.
// - trigger with program select set; ours loads buffer, not drops it.
// - program writes only to segments left open by lock field.
// - blocks are eight aligned words starting at low bits 000.
// - each block operation erases sixteen, writes eight, its writes never cross the block.
// - each word loaded by own sequence in order 000 to 111.
// - trigger at low bits 111 erases sixteen and commits eight words.
// - two setup cycles follow the trigger before erase and write.
// - core stalls for about 4 ms during erase, clocks keep running.
// - execution resumes at third instruction after the trigger.
// - unlock port reads as zero.
// - read start and trigger only settable by software, cleared by hardware.
// - select clear targets data storage, set targets program storage; ours has no data read, a read start with select clear does nothing.
// - reset during a write sets the abort flag.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "spnvm_consts.vh"
`default_nettype none
module spnvm_ctrl #(
  parameter integer ERASE_CYC  = (`SPNVM_ERASE_US * 1000) / `SPNVM_CLK_NS,
  parameter integer DWRITE_CYC = (`SPNVM_DWRITE_US * 1000) / `SPNVM_CLK_NS,
  parameter integer TW         = 20,
  parameter [1:0]   LOCK_RESET = 2'b11
) (
  input  wire        mclk,
  input  wire        reset,
  input  wire        warm_reset_seen,
  input  wire [1:0]  self_program_lock,
  input  wire [2:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_q,
  output reg         core_discard_q,
  output reg         core_stall_q,
  output reg         completion_flag_q,
  output reg         data_wr_req_q,
  output reg  [7:0]  data_wr_addr_q,
  output reg  [7:0]  data_wr_byte_q,
  input  wire        data_wr_done,
  output reg         prog_rd_req_q,
  output reg  [12:0] prog_rd_addr_q,
  input  wire [13:0] prog_rd_word,
  output reg         prog_wr_q,
  output reg         prog_erase_q,
  output reg  [12:0] prog_addr_q,
  output reg  [13:0] prog_word_q
);
  // states of the write sequencer, one-hot
  localparam [5:0] S_IDLE  = 6'b000001;
  localparam [5:0] S_DWR   = 6'b000010;
  localparam [5:0] S_SETUP = 6'b000100;
  localparam [5:0] S_ERASE = 6'b001000;
  localparam [5:0] S_PROG  = 6'b010000;
  localparam [5:0] S_DONE  = 6'b100000;

  reg [7:0]  nv_address_low_q;
  reg [4:0]  nv_address_high_q;
  reg [7:0]  nv_data_low_q;
  reg [5:0]  nv_data_high_q;
  reg        program_space_select_q;
  reg        modify_arm_bit_q;
  reg        trigger_q;
  reg        rd_start_q;
  reg        abort_flag_q;
  reg [1:0]  unlock_q;        // 0 none, 1 saw 55h, 2 saw AAh
  reg [5:0]  state_q;
  reg [1:0]  rd_cnt_q;
  reg [1:0]  setup_q;
  reg [3:0]  prog_idx_q;
  reg [12:0] blk_base_q;
  reg        tmr_start_q;
  reg [TW-1:0] tmr_load_q;
  reg        unlocked;
  wire       tmr_busy;
  wire       tmr_done;
  wire       tmr_end;
  wire [13:0] buf_rd;
  wire [12:0] full_addr;
  wire       seg_open;
  wire       wr_ctrl;
  wire       wr_trig_ok;
  wire       buf_we;

  assign full_addr = {nv_address_high_q, nv_address_low_q};
  assign wr_ctrl   = reg_wr && (reg_addr == `SPNVM_A_CTRL);
  // an older run expiring just as a new one starts is not the new run's end
  assign tmr_end   = tmr_done && !tmr_start_q;

  // lock field: 11 open, 10 lower eighth locked, 01 lower half, 00 all
  assign seg_open = (self_program_lock == 2'b11) ? 1'b1 :
                    (self_program_lock == 2'b10) ? (full_addr[12:10] != 3'h0) :
                    (self_program_lock == 2'b01) ? full_addr[12] : 1'b0;

  // trigger accepted only after full unlock and with arm set
  always @* begin
    unlocked = (unlock_q == 2'd2);
  end
  assign wr_trig_ok = wr_ctrl && reg_wdata[`SPNVM_B_WR] && unlocked
                      && modify_arm_bit_q && (state_q == S_IDLE);
  assign buf_we = wr_trig_ok && reg_wdata[`SPNVM_B_PGM] && seg_open;

  spnvm_buf #(.WIDTH(14), .DEPTH(`SPNVM_BLK_WORDS), .AW(3)) u_buf (
    .mclk      (mclk),
    .wr_en     (buf_we),
    .wr_idx    (nv_address_low_q[2:0]),
    .wr_data   ({nv_data_high_q, nv_data_low_q}),
    .rd_idx    (prog_idx_q[2:0]),
    .rd_data_q (buf_rd)
  );

  spnvm_timer #(.CW(TW)) u_tmr (
    .mclk   (mclk),
    .reset  (reset),
    .start  (tmr_start_q),
    .load   (tmr_load_q),
    .busy_q (tmr_busy),
    .done_q (tmr_done)
  );

  // unlock sequence tracker: any other access breaks it
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      unlock_q <= 2'd0;
    end else if (reg_wr && reg_addr == `SPNVM_A_UNLOCK) begin
      if (reg_wdata == `SPNVM_KEY1) begin
        unlock_q <= 2'd1;
      end else if (reg_wdata == `SPNVM_KEY2 && unlock_q == 2'd1) begin
        unlock_q <= 2'd2;
      end else begin
        unlock_q <= 2'd0;
      end
    end else if (reg_wr || reg_rd) begin
      unlock_q <= 2'd0;
    end
  end

  // software-visible registers and flags
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      nv_address_low_q       <= `SPNVM_ZERO8;
      nv_address_high_q      <= 5'h00;
      nv_data_low_q          <= `SPNVM_ZERO8;
      nv_data_high_q         <= 6'h00;
      program_space_select_q <= 1'b0;
      modify_arm_bit_q       <= 1'b0;
      completion_flag_q      <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `SPNVM_A_ADDR_LO) begin
        nv_address_low_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `SPNVM_A_ADDR_HI) begin
        nv_address_high_q <= reg_wdata[4:0];
      end
      // program read result, else software write
      if (prog_rd_req_q) begin
        nv_data_low_q  <= prog_rd_word[7:0];
        nv_data_high_q <= prog_rd_word[13:8];
      end else begin
        if (reg_wr && reg_addr == `SPNVM_A_DATA_LO) begin
          nv_data_low_q <= reg_wdata;
        end
        if (reg_wr && reg_addr == `SPNVM_A_DATA_HI) begin
          nv_data_high_q <= reg_wdata[5:0];
        end
      end
      if (wr_ctrl) begin
        program_space_select_q <= reg_wdata[`SPNVM_B_PGM];
        modify_arm_bit_q       <= reg_wdata[`SPNVM_B_ARM];
      end
      // set wins over a software clear
      if (state_q == S_DWR && (data_wr_done || tmr_end)) begin
        completion_flag_q <= 1'b1;
      end else if (reg_wr && reg_addr == `SPNVM_A_FLAGS && !reg_wdata[`SPNVM_B_DONE]) begin
        completion_flag_q <= 1'b0;
      end
    end
  end

  // abort flag: caught after release of reset if a write was cut off
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      abort_flag_q <= 1'b0;
    end else if (warm_reset_seen) begin
      abort_flag_q <= 1'b1;
    end else if (wr_ctrl && !reg_wdata[`SPNVM_B_ABORT]) begin
      abort_flag_q <= 1'b0;
    end
  end

  // program read: start now, request and discard in second following cycle
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_start_q     <= 1'b0;
      rd_cnt_q       <= 2'd0;
      prog_rd_req_q  <= 1'b0;
      prog_rd_addr_q <= 13'h0000;
      core_discard_q <= 1'b0;
    end else begin
      prog_rd_req_q  <= 1'b0;
      core_discard_q <= 1'b0;
      if (wr_ctrl && reg_wdata[`SPNVM_B_RD] && reg_wdata[`SPNVM_B_PGM]
          && !rd_start_q) begin
        rd_start_q     <= 1'b1;
        rd_cnt_q       <= 2'd1;
        prog_rd_addr_q <= full_addr;
      end else if (rd_start_q && rd_cnt_q == 2'd1) begin
        rd_cnt_q       <= 2'd2;
        core_discard_q <= 1'b1;
        prog_rd_req_q  <= 1'b1;
      end else if (rd_start_q) begin
        rd_start_q <= 1'b0;
        rd_cnt_q   <= 2'd0;
      end
    end
  end

  // write sequencer
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q        <= S_IDLE;
      trigger_q      <= 1'b0;
      setup_q        <= 2'd0;
      prog_idx_q     <= 4'h0;
      blk_base_q     <= 13'h0000;
      tmr_start_q    <= 1'b0;
      tmr_load_q     <= {TW{1'b0}};
      core_stall_q   <= 1'b0;
      data_wr_req_q  <= 1'b0;
      data_wr_addr_q <= `SPNVM_ZERO8;
      data_wr_byte_q <= `SPNVM_ZERO8;
      prog_wr_q      <= 1'b0;
      prog_erase_q   <= 1'b0;
      prog_addr_q    <= 13'h0000;
      prog_word_q    <= 14'h0000;
    end else begin
      tmr_start_q   <= 1'b0;
      data_wr_req_q <= 1'b0;
      prog_wr_q     <= 1'b0;
      prog_erase_q  <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (wr_trig_ok && !reg_wdata[`SPNVM_B_PGM]) begin
            trigger_q      <= 1'b1;
            data_wr_req_q  <= 1'b1;
            data_wr_addr_q <= nv_address_low_q;
            data_wr_byte_q <= nv_data_low_q;
            tmr_start_q    <= 1'b1;
            tmr_load_q     <= DWRITE_CYC[TW-1:0];
            state_q        <= S_DWR;
          end else if (buf_we && nv_address_low_q[2:0] == `SPNVM_LOW3_LAST) begin
            trigger_q  <= 1'b1;
            setup_q    <= 2'd0;
            blk_base_q <= {full_addr[12:3], 3'h0};
            state_q    <= S_SETUP;
          end
        end
        // data write runs on even if arm is cleared meanwhile
        S_DWR: begin
          if (data_wr_done || tmr_end) begin
            trigger_q <= 1'b0;
            state_q   <= S_IDLE;
          end
        end
        // two setup cycles let the core run its two no-ops
        S_SETUP: begin
          setup_q <= setup_q + 2'd1;
          if (setup_q == `SPNVM_SETUP_CYC - 1) begin
            core_stall_q <= 1'b1;
            prog_erase_q <= 1'b1;
            prog_addr_q  <= {blk_base_q[12:4], 4'h0};
            tmr_start_q  <= 1'b1;
            tmr_load_q   <= ERASE_CYC[TW-1:0];
            prog_idx_q   <= 4'h0;
            state_q      <= S_ERASE;
          end
        end
        S_ERASE: begin
          if (tmr_end) begin
            state_q <= S_PROG;
          end
        end
        // commit buffered words one per cycle within the block
        S_PROG: begin
          prog_idx_q <= prog_idx_q + 4'h1;
          if (prog_idx_q != 4'h0) begin
            prog_wr_q   <= 1'b1;
            prog_addr_q <= blk_base_q | {10'h000, prog_idx_q[2:0] - 3'h1};
            prog_word_q <= buf_rd;
          end
          if (prog_idx_q == `SPNVM_BLK_WORDS) begin
            state_q <= S_DONE;
          end
        end
        S_DONE: begin
          core_stall_q <= 1'b0;
          trigger_q    <= 1'b0;
          state_q      <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // read data, one cycle after the strobe; unlock port reads zero
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= `SPNVM_ZERO8;
    end else if (reg_rd) begin
      case (reg_addr)
        `SPNVM_A_ADDR_LO: reg_rdata_q <= nv_address_low_q;
        `SPNVM_A_ADDR_HI: reg_rdata_q <= {3'h0, nv_address_high_q};
        `SPNVM_A_DATA_LO: reg_rdata_q <= nv_data_low_q;
        `SPNVM_A_DATA_HI: reg_rdata_q <= {2'h0, nv_data_high_q};
        `SPNVM_A_CTRL:    reg_rdata_q <= {program_space_select_q, 3'h0, abort_flag_q,
                                          modify_arm_bit_q, trigger_q, rd_start_q};
        `SPNVM_A_FLAGS:   reg_rdata_q <= {7'h00, completion_flag_q};
        default:          reg_rdata_q <= `SPNVM_ZERO8;
      endcase
    end else begin
      reg_rdata_q <= `SPNVM_ZERO8;
    end
  end
endmodule
`default_nettype wire

// file: rtl/spnvm_consts.vh
// Purpose: constants for the self-program nonvolatile access controller
// Assumes: 125 MHz core clock, byte-wide register port
// Notes:   offsets are word indices on the plain register port
`ifndef SPNVM_CONSTS_VH
`define SPNVM_CONSTS_VH

// register offsets
`define SPNVM_A_ADDR_LO   3'h0
`define SPNVM_A_ADDR_HI   3'h1
`define SPNVM_A_DATA_LO   3'h2
`define SPNVM_A_DATA_HI   3'h3
`define SPNVM_A_CTRL      3'h4
`define SPNVM_A_UNLOCK    3'h5
`define SPNVM_A_FLAGS     3'h6

// control register fields
`define SPNVM_B_RD        0
`define SPNVM_B_WR        1
`define SPNVM_B_ARM       2
`define SPNVM_B_ABORT     3
`define SPNVM_B_PGM       7
// flags register field
`define SPNVM_B_DONE      0

// unlock values
`define SPNVM_KEY1        8'h55
`define SPNVM_KEY2        8'hAA

// field masks of the high registers, block and zero constants
`define SPNVM_ADDR_HI_MSK 8'h1F
`define SPNVM_DATA_HI_MSK 8'h3F
`define SPNVM_LOW3_LAST   3'h7
`define SPNVM_BLK_WORDS   8
`define SPNVM_ZERO8       8'h00

// timing: ns per clock, erase stall in us, data write in us
`define SPNVM_CLK_NS      8
`define SPNVM_ERASE_US    4000
`define SPNVM_DWRITE_US   4000
`define SPNVM_SETUP_CYC   2

`endif

// file: rtl/spnvm_buf.v
// Purpose: eight-word program write buffer
// Assumes: single write port, registered read port
// Notes:   read data come out of a register
`timescale 1ns/1ps
`default_nettype none
module spnvm_buf #(
  parameter WIDTH = 14,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             mclk,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_idx,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_idx,
  output reg  [WIDTH-1:0] rd_data_q
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // store and registered read
  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data_q <= mem[rd_idx];
  end
endmodule
`default_nettype wire

// file: rtl/spnvm_timer.v
// Purpose: down counter timing an erase or data write
// Assumes: start is a one-cycle pulse
// Notes:   done pulses one cycle when the count expires
`timescale 1ns/1ps
`default_nettype none
module spnvm_timer #(
  parameter CW = 20
) (
  input  wire          mclk,
  input  wire          reset,
  input  wire          start,
  input  wire [CW-1:0] load,
  output reg           busy_q,
  output reg           done_q
);
  reg [CW-1:0] cnt_q;

  // count down while busy
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_q  <= {CW{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        cnt_q  <= load;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/spnvm_ctrl_sva.sv
// Purpose: port-level checks for the self-program access controller
// Assumes: one clock, async active-high reset
// Notes:   bound into spnvm_ctrl below
`timescale 1ns/1ps
`include "spnvm_consts.vh"
`default_nettype none
module spnvm_ctrl_sva (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [2:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata_q,
  input wire logic        core_discard_q,
  input wire logic        core_stall_q,
  input wire logic        completion_flag_q,
  input wire logic        data_wr_req_q,
  input wire logic        data_wr_done,
  input wire logic        prog_rd_req_q,
  input wire logic        prog_wr_q,
  input wire logic        prog_erase_q,
  input wire logic [12:0] prog_addr_q
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // upper address bits of the last erase, for the block span check
  logic [8:0] erase_hi_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      erase_hi_q <= 9'h000;
    end else if (prog_erase_q) begin
      erase_hi_q <= prog_addr_q[12:4];
    end
  end

  // register port answers
  a_unlock_zero: assert property (
    reg_rd && reg_addr == `SPNVM_A_UNLOCK |=> reg_rdata_q == 8'h00)
    else $error("unlock port read back nonzero");
  // data write start needs both keys then an armed trigger
  a_dwrite_keys: assert property (
    data_wr_req_q |-> $past(reg_wr, 2) && $past(reg_wdata, 2) == `SPNVM_KEY2
      && $past(reg_wr, 3) && $past(reg_wdata, 3) == `SPNVM_KEY1)
    else $error("data write started without key sequence");
  a_dwrite_arm: assert property (
    data_wr_req_q |-> $past(reg_wr) && $past(reg_addr) == `SPNVM_A_CTRL
      && $past(reg_wdata[`SPNVM_B_WR]) && $past(reg_wdata[`SPNVM_B_ARM]))
    else $error("data write started without arm");
  // program read steals the second cycle
  a_read_slot: assert property (
    reg_wr && reg_addr == `SPNVM_A_CTRL && reg_wdata[`SPNVM_B_RD] && reg_wdata[`SPNVM_B_PGM]
      |-> !prog_rd_req_q ##1 !prog_rd_req_q ##1 (prog_rd_req_q && core_discard_q))
    else $error("program read not in second cycle");
  // completion flag set on end and held until software clears it
  a_done_flag: assert property (
    data_wr_done |=> completion_flag_q)
    else $error("completion flag not set");
  a_flag_sticky: assert property (
    completion_flag_q && !(reg_wr && reg_addr == `SPNVM_A_FLAGS) |=> completion_flag_q)
    else $error("completion flag dropped by hardware");
  // erase aligned to sixteen words, erase and writes inside the stall
  a_erase_align: assert property (
    prog_erase_q |-> prog_addr_q[3:0] == 4'h0 && !prog_wr_q)
    else $error("erase address not aligned");
  a_erase_stall: assert property (
    prog_erase_q |-> core_stall_q ##1 core_stall_q[*8])
    else $error("core not stalled across erase");
  a_wr_stall: assert property (
    prog_wr_q |-> core_stall_q && !prog_erase_q && prog_addr_q[12:4] == erase_hi_q)
    else $error("program write outside stall or erased block");
  a_wr_order: assert property (
    prog_wr_q && $past(prog_wr_q) |-> prog_addr_q == $past(prog_addr_q) + 13'h0001)
    else $error("program writes not ascending");

  // main scenarios
  c_dwrite: cover property (data_wr_req_q);
  c_pread: cover property (prog_rd_req_q);
  c_block: cover property ($fell(core_stall_q));
endmodule
bind spnvm_ctrl spnvm_ctrl_sva u_sva (
  .mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .core_discard_q,
  .core_stall_q, .completion_flag_q, .data_wr_req_q, .data_wr_done, .prog_rd_req_q,
  .prog_wr_q, .prog_erase_q, .prog_addr_q);
`default_nettype wire

// file: testbench/spnvm_store_model.sv
// Purpose: storage arrays behind the controller: data bytes and program words
// Assumes: data write answer delay set by dly, zero means never answers
// Notes:   read word port shows the inverse of the last word when not selected
`timescale 1ns/1ps
`default_nettype none
module spnvm_store_model (
  input  wire logic        mclk,
  input  wire logic        d_req,
  input  wire logic [7:0]  d_addr,
  input  wire logic [7:0]  d_byte,
  output logic             d_done,
  input  wire logic        p_rd,
  input  wire logic [12:0] p_rd_addr,
  output logic      [13:0] p_word,
  input  wire logic        p_wr,
  input  wire logic        p_erase,
  input  wire logic [12:0] p_addr,
  input  wire logic [13:0] p_data
);
  logic [13:0] mem [0:8191];
  logic [13:0] last_q;
  logic [7:0]  last_addr;
  logic [7:0]  last_byte;
  int          dly;
  int          cnt;
  int          n_dreq;
  int          n_erase;
  int          n_wr;
  // program array starts with an address pattern
  initial begin
    for (int i = 0; i < 8192; i++)
      mem[i] = 14'(i) ^ 14'h1555;
    {dly, cnt, n_dreq, n_erase, n_wr} = {32'd3, 128'd0};
    d_done = 1'b0;
    last_q = 14'h0000;
  end
  // word port shows the array word only in the sampled cycle
  assign p_word = p_rd ? mem[p_rd_addr] : ~last_q;
  // data write answer, erase of sixteen, commit of buffered words
  always @(posedge mclk) begin
    d_done <= 1'b0;
    if (d_req) begin
      n_dreq <= n_dreq + 1;
      {last_addr, last_byte} <= {d_addr, d_byte};
      cnt <= dly;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      d_done <= (cnt == 1);
    end
    if (p_rd)
      last_q <= mem[p_rd_addr];
    if (p_erase) begin
      n_erase <= n_erase + 1;
      for (int j = 0; j < 16; j++)
        mem[{p_addr[12:4], 4'(j)}] <= 14'h3FFF;
    end
    if (p_wr) begin
      n_wr <= n_wr + 1;
      mem[p_addr] <= p_data;
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Purpose: register-level test of the self-program access controller
// Assumes: erase and data write counts shortened to 20 cycles
// Notes:   storage model answers data writes; read and write tasks drive the port
`timescale 1ns/1ps
`include "spnvm_consts.vh"
`default_nettype none
module tb;
  localparam integer ECYC = 20;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        warm_reset_seen = 1'b0;
  logic [1:0]  self_program_lock = 2'b11;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire  [7:0]  reg_rdata_q, data_wr_addr_q, data_wr_byte_q;
  wire         core_discard_q, core_stall_q, completion_flag_q, data_wr_req_q, data_wr_done;
  wire         prog_rd_req_q, prog_wr_q, prog_erase_q;
  wire  [12:0] prog_rd_addr_q, prog_addr_q;
  wire  [13:0] prog_rd_word, prog_word_q;
  int          err_count = 0;
  int          checks = 0;
  int          n;
  int          st;
  logic [13:0] ev;
  logic [13:0] pw = 14'h1234 ^ 14'h1555;

  spnvm_ctrl #(.ERASE_CYC(ECYC), .DWRITE_CYC(ECYC)) DUT (
    .mclk, .reset, .warm_reset_seen, .self_program_lock, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .core_discard_q, .core_stall_q, .completion_flag_q, .data_wr_req_q,
    .data_wr_addr_q, .data_wr_byte_q, .data_wr_done, .prog_rd_req_q, .prog_rd_addr_q,
    .prog_rd_word, .prog_wr_q, .prog_erase_q, .prog_addr_q, .prog_word_q);
  spnvm_store_model u_mem (
    .mclk(mclk), .d_req(data_wr_req_q), .d_addr(data_wr_addr_q), .d_byte(data_wr_byte_q),
    .d_done(data_wr_done), .p_rd(prog_rd_req_q), .p_rd_addr(prog_rd_addr_q),
    .p_word(prog_rd_word), .p_wr(prog_wr_q), .p_erase(prog_erase_q), .p_addr(prog_addr_q),
    .p_data(prog_word_q));

  // 125 MHz clock
  always #4 mclk = ~mclk;

  // comparison and closing report
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    err_count++;
    $display("[ERR] %s expected done seen timeout", what);
    test_done();
  endtask
  // one-cycle strobes, back to back
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, 2'b10};
    @(posedge mclk);
  endtask
  task automatic rc(input string what, input logic [2:0] a, input logic [7:0] exp);
    {reg_addr, reg_wr, reg_rd} <= {a, 2'b01};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(what, 16'(reg_rdata_q), 16'(exp));
  endtask
  task automatic idle(input int c);
    {reg_wr, reg_rd} <= 2'b00;
    repeat (c) @(posedge mclk);
    #1;
  endtask
  // keys and trigger back to back, nothing in between
  task automatic unlock(input logic [7:0] c);
    wr(`SPNVM_A_UNLOCK, `SPNVM_KEY1);
    wr(`SPNVM_A_UNLOCK, `SPNVM_KEY2);
    wr(`SPNVM_A_CTRL, c);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    // all offsets clear after reset, unlock and unmapped read zero
    for (int a = 0; a < 8; a++)
      rc("reset value", 3'(a), 8'h00);
    // unarmed, swapped keys, interrupted keys: trigger refused
    wr(`SPNVM_A_ADDR_LO, 8'h3C);
    unlock(8'h02);
    rc("trigger unarmed", `SPNVM_A_CTRL, 8'h00);
    wr(`SPNVM_A_CTRL, 8'h04);
    wr(`SPNVM_A_UNLOCK, `SPNVM_KEY2);
    wr(`SPNVM_A_UNLOCK, `SPNVM_KEY1);
    wr(`SPNVM_A_CTRL, 8'h06);
    rc("keys swapped", `SPNVM_A_CTRL, 8'h04);
    wr(`SPNVM_A_UNLOCK, `SPNVM_KEY1);
    rc("flags", `SPNVM_A_FLAGS, 8'h00);
    wr(`SPNVM_A_UNLOCK, `SPNVM_KEY2);
    wr(`SPNVM_A_CTRL, 8'h06);
    rc("keys broken", `SPNVM_A_CTRL, 8'h04);
    chk("refused starts", 16'(u_mem.n_dreq), 16'h0000);
    // prompt answer with arm dropped mid-write, then silent far side ended by timer
    for (int k = 0; k < 2; k++) begin
      u_mem.dly = (k == 0) ? 3 : 0;
      wr(`SPNVM_A_DATA_LO, 8'hA5 + 8'(k));
      wr(`SPNVM_A_CTRL, 8'h04); // re-arm, the first pass clears arm
      unlock(8'h06);
      rc("trigger held", `SPNVM_A_CTRL, 8'h06);
      if (k == 0)
        wr(`SPNVM_A_CTRL, 8'h00);
      n = 0;
      idle(1);
      while (completion_flag_q !== 1'b1 && n < 100) begin
        idle(1);
        n++;
      end
      if (n == 100)
        hang("completion flag");
      chk("write address", 16'(u_mem.last_addr), 16'h003C);
      chk("write byte", 16'(u_mem.last_byte), 16'(8'hA5 + 8'(k)));
      rc("ctrl after write", `SPNVM_A_CTRL, k ? 8'h04 : 8'h00);
      idle(5);
      rc("flag kept", `SPNVM_A_FLAGS, 8'h01);
      wr(`SPNVM_A_FLAGS, 8'h00);
      rc("flag cleared", `SPNVM_A_FLAGS, 8'h00);
    end
    // program read lands in both data bytes and stays
    wr(`SPNVM_A_ADDR_HI, 8'h12);
    wr(`SPNVM_A_ADDR_LO, 8'h34);
    wr(`SPNVM_A_CTRL, 8'h81);
    idle(3);
    rc("word low", `SPNVM_A_DATA_LO, pw[7:0]);
    rc("word high", `SPNVM_A_DATA_HI, {2'b00, pw[13:8]});
    rc("read bit", `SPNVM_A_CTRL, 8'h80);
    idle(4);
    rc("word kept", `SPNVM_A_DATA_LO, pw[7:0]);
    wr(`SPNVM_A_DATA_LO, 8'h11);
    rc("data written", `SPNVM_A_DATA_LO, 8'h11);
    wr(`SPNVM_A_CTRL, 8'h01);
    idle(3);
    rc("data space read", `SPNVM_A_DATA_LO, 8'h11);
    // open block then locked block, one key sequence per word
    for (int b = 0; b < 2; b++) begin
      self_program_lock <= b ? 2'b00 : 2'b11;
      wr(`SPNVM_A_ADDR_HI, 8'h00);
      wr(`SPNVM_A_CTRL, 8'h84);
      for (int i = 0; i < 8; i++) begin
        wr(`SPNVM_A_ADDR_LO, 8'h48 + 8'(16 * b + i));
        wr(`SPNVM_A_DATA_LO, 8'(i * 17));
        wr(`SPNVM_A_DATA_HI, 8'(i + 32));
        unlock(8'h86);
        if (i < 7)
          rc("buffer load", `SPNVM_A_CTRL, 8'h84);
      end
      {n, st} = 64'd0;
      idle(1);
      while (n < 200 && (st == 0 || core_stall_q === 1'b1)) begin
        st += (core_stall_q === 1'b1);
        idle(1);
        n++;
      end
      if (b == 0 && n == 200)
        hang("block write");
      chk("stall length", 16'(st >= ECYC), 16'(b == 0));
      rc("trigger after block", `SPNVM_A_CTRL, 8'h84);
      for (int i = 0; i < 16; i++) begin
        ev = (i < 8) ? 14'h3FFF : {6'(i + 24), 8'((i - 8) * 17)};
        ev = b ? (14'(64 + 16 * b + i) ^ 14'h1555) : ev;
        chk("program word", 16'(u_mem.mem[64 + 16 * b + i]), 16'(ev));
      end
    end
    chk("erase count", 16'(u_mem.n_erase), 16'h0001);
    chk("word writes", 16'(u_mem.n_wr), 16'h0008);
    // warm reset cut a write short, software clears the abort flag
    warm_reset_seen <= 1'b1;
    idle(1);
    warm_reset_seen <= 1'b0;
    rc("abort flag", `SPNVM_A_CTRL, 8'h8C);
    wr(`SPNVM_A_CTRL, 8'h84);
    rc("abort cleared", `SPNVM_A_CTRL, 8'h84);
    test_done();
  end
endmodule
`default_nettype wire
